// >>> verilog/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;
    // Register offsets on the byte-wide control port.
    localparam logic [5:0] OFS_CLOCK_PRESCALE_ENABLE_CTRL = 6'h00;
    localparam logic [5:0] OFS_RAMP_AND_OVERRIDE_CTRL     = 6'h01;
    localparam logic [5:0] OFS_OUTPUT_ROUTE_UPDATE_CTRL   = 6'h02;
    localparam logic [5:0] OFS_OVERRIDE_LEVEL_CTRL        = 6'h03;
    localparam logic [5:0] OFS_COMMAND_STROBE_CTRL        = 6'h04;
    localparam logic [5:0] OFS_STATUS                     = 6'h0E;
    localparam logic [5:0] OFS_CAPTURE_FIRST_LOW          = 6'h22;
    localparam logic [5:0] OFS_CAPTURE_FIRST_HIGH         = 6'h23;
    localparam logic [5:0] OFS_CAPTURE_SECOND_LOW         = 6'h24;
    localparam logic [5:0] OFS_CAPTURE_SECOND_HIGH        = 6'h25;
    localparam logic [2:0] OFS_COMPARE_BLOCK              = 3'h5;
    localparam logic [5:0] OFS_FIRST_CLEAR_HIGH           = 6'h2B;
    localparam logic [5:0] OFS_SECOND_CLEAR_HIGH          = 6'h2F;

    // Compare buffer indices: first set, first clear, second set, second clear.
    localparam logic [1:0] CMP_A_SET = 2'h0;
    localparam logic [1:0] CMP_A_CLR = 2'h1;
    localparam logic [1:0] CMP_B_SET = 2'h2;
    localparam logic [1:0] CMP_B_CLR = 2'h3;

    // Field positions.
    localparam int ENABLE_BIT      = 0;
    localparam int XDIV_LSB        = 1;
    localparam int CDIV_LSB        = 3;
    localparam int CLKSRC_LSB      = 5;
    localparam int OVR_BIT         = 0;
    localparam int AUTO_BIT        = 1;
    localparam int FIFTY_BIT       = 3;
    localparam int C_ROUTE_BIT     = 6;
    localparam int D_ROUTE_BIT     = 7;
    localparam int DIS_EOC_BIT     = 7;
    localparam int CMD_LSB         = 0;
    localparam int CMD_MSB         = 4;
    localparam int ST_ENABLE_READY_FLAG_BIT    = 0;
    localparam int ST_COMMAND_READY_FLAG_BIT   = 1;

    // Command strobe bits inside the command code.
    localparam int CMD_LOAD_EOC  = 0;
    localparam int CMD_LOAD_NOW  = 1;
    localparam int CMD_RESTART   = 2;
    localparam int CMD_CAPTURE_A = 3;
    localparam int CMD_CAPTURE_B = 4;

    // Ramp modes.
    localparam logic [1:0] SINGLE_RAMP   = 2'h0;
    localparam logic [1:0] DOUBLE_RAMP   = 2'h1;
    localparam logic [1:0] QUAD_RAMP     = 2'h2;
    localparam logic [1:0] UP_DOWN_SLOPE = 2'h3;

    // Counter divider reload values for divide by 1, 4 and 32.
    localparam logic [4:0] CDIV_LIM_1  = 5'h00;
    localparam logic [4:0] CDIV_LIM_4  = 5'h03;
    localparam logic [4:0] CDIV_LIM_32 = 5'h1F;

    // Crossing divider masks for divide by 1, 2, 4 and 8.
    localparam logic [2:0] XMASK_1 = 3'h0;
    localparam logic [2:0] XMASK_2 = 3'h1;
    localparam logic [2:0] XMASK_4 = 3'h3;
    localparam logic [2:0] XMASK_8 = 3'h7;

    // Crossing-divider ticks a write needs to reach the core side.
    localparam logic [1:0] SYNC_TICKS = 2'h2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// >>> verilog/pwm_timer_control_regs.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// - Counter divider code 0,1,2 divides by 1,4,32; code 3 reserved.
// - Crossing divider codes 0..3 divide the core clock by 1,2,4,8.
// - Enable bit writes cross automatically to the core side; 1 runs, 0 stops.
// - Enable bit writes take effect only while enable ready is high; disable-at-cycle-end clears it while ready is low.
// - Enable bit is writable whenever enable ready is high; other first-register fields lock while enabled.
// - Ramp mode 0,1,2,3 selects single, double, quad ramp, up-down slope.
// - Bits 7 and 6 route waveform A (0) or B (1) to outputs D, C.
// - With mirror set, second compare writes also land in first compare registers.
// - With auto-load, writing second clear high byte requests a cycle-end load.
// - With mirror and auto-load, first clear high byte writes also request one.
// - Override bit replaces waveform outputs by per-phase level bits.
// - Levels bits 0-3 for A, 4-7 for B; A-off, A-on, B-off, B-on ascending.
// - Level bits have no effect unless override is set.
// - Single ramp: A uses only A-off/A-on, B only B-off/B-on levels.
// - Disable-at-cycle-end stops the counter at cycle end; enable ready low until then.
// - Disable-at-cycle-end is ignored while the enable bit is crossing.
// - Capture strobes copy the counter into capture registers after crossing.
// - Restart strobe restarts the counter after crossing.
// - Immediate load strobe moves all buffered registers after crossing.
// - Cycle-end load strobe moves buffered registers at the next cycle end.
// - Command strobes are ignored while an earlier command is crossing.
// - Command ready drops on a command and returns once it reached the core.
// - Clock source field: 0 oscillator, 1 reserved, 2 external, 3 system clock.
module pwm_timer_control_regs (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [5:0]   addr,
    input  wire logic [7:0]   wdata,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [7:0]   rdata,
    input  wire logic         cycle_end,
    input  wire logic [11:0]  counter_value,
    input  wire logic [1:0]   ramp_phase,
    input  wire logic         phase_a_on,
    input  wire logic         phase_b_on,
    input  wire logic         wave_a_raw,
    input  wire logic         wave_b_raw,
    output logic              core_enable,
    output logic              count_tick,
    output logic              sync_tick,
    output logic [1:0]        core_clock_source,
    output logic [1:0]        ramp_mode_field,
    output logic              enable_ready_flag,
    output logic              command_ready_flag,
    output logic              capture_a_pulse,
    output logic              capture_b_pulse,
    output logic              restart_pulse,
    output logic              load_pulse,
    output logic [11:0]       cmp_a_set,
    output logic [11:0]       cmp_a_clr,
    output logic [11:0]       cmp_b_set,
    output logic [11:0]       cmp_b_clr,
    output logic              waveform_a,
    output logic              waveform_b,
    output logic              out_c_wave,
    output logic              out_d_wave
);
    import pwm_ctrl_pkg::*;

    typedef struct packed {
        logic [1:0]        clk_src;
        logic [1:0]        cdiv;
        logic [1:0]        xdiv;
        logic              enable;
        logic [1:0]        ramp;
        logic              d_route;
        logic              c_route;
        logic              fifty;
        logic              auto_load;
        logic              ovr;
        logic [7:0]        levels;
        logic [3:0][11:0]  cmp_buf;
        logic [3:0][11:0]  cmp_act;
        logic [11:0]       cap_a;
        logic [11:0]       cap_b;
        logic              en_busy;
        logic [1:0]        en_cnt;
        logic              core_en;
        logic              dis_arm;
        logic              cmd_busy;
        logic [1:0]        cmd_cnt;
        logic [4:0]        cmd_code;
        logic              eoc_arm;
        logic [2:0]        xdiv_cnt;
        logic              sync_tick;
        logic [4:0]        cdiv_cnt;
        logic              count_tick;
        logic [7:0]        rdata;
        logic              en_rdy;
        logic              cmd_rdy;
        logic              cap_a_p;
        logic              cap_b_p;
        logic              restart_p;
        logic              load_p;
        logic              wave_a;
        logic              wave_b;
        logic              out_c;
        logic              out_d;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for dividers, crossings, register port and outputs.
    always_comb begin
        logic [2:0]  xmask;
        logic [4:0]  clim;
        logic [1:0]  idx;
        logic [3:0]  nib;
        logic        cmd_req_ok;
        xmask      = XMASK_1;
        clim       = CDIV_LIM_1;
        idx        = 2'h0;
        nib        = 4'h0;
        cmd_req_ok = 1'b0;
        s_nxt           = s_r;
        s_nxt.rdata     = RESET_BYTE;
        s_nxt.cap_a_p   = 1'b0;
        s_nxt.cap_b_p   = 1'b0;
        s_nxt.restart_p = 1'b0;
        s_nxt.load_p    = 1'b0;

        // Crossing divider: a tick every 1, 2, 4 or 8 clocks.
        unique case (s_r.xdiv)
            2'h0: xmask = XMASK_1;
            2'h1: xmask = XMASK_2;
            2'h2: xmask = XMASK_4;
            2'h3: xmask = XMASK_8;
        endcase
        s_nxt.xdiv_cnt  = s_r.xdiv_cnt + 3'h1;
        s_nxt.sync_tick = ((s_r.xdiv_cnt & xmask) == xmask);

        // Counter divider; the reserved code falls back to divide by one.
        unique case (s_r.cdiv)
            2'h1:    clim = CDIV_LIM_4;
            2'h2:    clim = CDIV_LIM_32;
            default: clim = CDIV_LIM_1;
        endcase
        if (s_r.core_en && s_r.cdiv_cnt >= clim) begin
            s_nxt.cdiv_cnt   = 5'h00;
            s_nxt.count_tick = 1'b1;
        end else if (s_r.core_en) begin
            s_nxt.cdiv_cnt   = s_r.cdiv_cnt + 5'h01;
            s_nxt.count_tick = 1'b0;
        end else begin
            s_nxt.cdiv_cnt   = 5'h00;
            s_nxt.count_tick = 1'b0;
        end

        // Enable crossing: the core side follows after two divider ticks.
        if (s_r.en_busy && s_r.sync_tick) begin
            if (s_r.en_cnt == SYNC_TICKS - 2'h1) begin
                s_nxt.core_en = s_r.enable;
                s_nxt.en_busy = 1'b0;
                s_nxt.en_cnt  = 2'h0;
            end else begin
                s_nxt.en_cnt = s_r.en_cnt + 2'h1;
            end
        end

        // A stopped core has no cycle end to wait for, so it disarms at once.
        if (s_r.dis_arm && (cycle_end || !s_r.core_en)) begin
            s_nxt.core_en = 1'b0;
            s_nxt.enable  = 1'b0;
            s_nxt.dis_arm = 1'b0;
        end

        // Buffered compare values waiting for the end of the counter cycle.
        if (s_r.eoc_arm && cycle_end) begin
            s_nxt.cmp_act = s_r.cmp_buf;
            s_nxt.load_p  = 1'b1;
            s_nxt.eoc_arm = 1'b0;
        end

        // Command crossing; the strobes fire once the code reaches the core.
        if (s_r.cmd_busy && s_r.sync_tick) begin
            if (s_r.cmd_cnt == SYNC_TICKS - 2'h1) begin
                s_nxt.cmd_busy  = 1'b0;
                s_nxt.cmd_cnt   = 2'h0;
                s_nxt.cap_a_p   = s_r.cmd_code[CMD_CAPTURE_A];
                s_nxt.cap_b_p   = s_r.cmd_code[CMD_CAPTURE_B];
                s_nxt.restart_p = s_r.cmd_code[CMD_RESTART];
                if (s_r.cmd_code[CMD_CAPTURE_A]) begin
                    s_nxt.cap_a = counter_value;
                end
                if (s_r.cmd_code[CMD_CAPTURE_B]) begin
                    s_nxt.cap_b = counter_value;
                end
                if (s_r.cmd_code[CMD_LOAD_NOW]) begin
                    s_nxt.cmp_act = s_r.cmp_buf;
                    s_nxt.load_p  = 1'b1;
                end
                if (s_r.cmd_code[CMD_LOAD_EOC]) begin
                    s_nxt.eoc_arm = 1'b1;
                end
            end else begin
                s_nxt.cmd_cnt = s_r.cmd_cnt + 2'h1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Register writes.
        if (wr_en) begin
            unique case (addr)
                OFS_CLOCK_PRESCALE_ENABLE_CTRL: begin
                    // Only the enable bit may move while the timer runs.
                    if (!(s_r.core_en || s_r.enable)) begin
                        s_nxt.clk_src = wdata[CLKSRC_LSB+:2];
                        s_nxt.cdiv    = wdata[CDIV_LSB+:2];
                        s_nxt.xdiv    = wdata[XDIV_LSB+:2];
                    end
                    if (!s_r.en_busy && !s_r.dis_arm) begin
                        s_nxt.enable  = wdata[ENABLE_BIT];
                        s_nxt.en_busy = 1'b1;
                        s_nxt.en_cnt  = 2'h0;
                    end
                end
                OFS_RAMP_AND_OVERRIDE_CTRL: begin
                    s_nxt.ramp = wdata[1:0];
                end
                OFS_OUTPUT_ROUTE_UPDATE_CTRL: begin
                    s_nxt.d_route   = wdata[D_ROUTE_BIT];
                    s_nxt.c_route   = wdata[C_ROUTE_BIT];
                    s_nxt.fifty     = wdata[FIFTY_BIT];
                    s_nxt.auto_load = wdata[AUTO_BIT];
                    s_nxt.ovr       = wdata[OVR_BIT];
                end
                OFS_OVERRIDE_LEVEL_CTRL: begin
                    s_nxt.levels = wdata;
                end
                OFS_COMMAND_STROBE_CTRL: begin
                    if (wdata[DIS_EOC_BIT] && !s_r.en_busy && !s_r.dis_arm) begin
                        s_nxt.dis_arm = 1'b1;
                    end
                    if (|wdata[CMD_MSB:CMD_LSB] && !s_r.cmd_busy) begin
                        s_nxt.cmd_code = wdata[CMD_MSB:CMD_LSB];
                        s_nxt.cmd_busy = 1'b1;
                        s_nxt.cmd_cnt  = 2'h0;
                    end
                end
                default: begin
                    if (addr[5:3] == OFS_COMPARE_BLOCK) begin
                        idx = addr[2:1];
                        if (addr[0]) begin
                            s_nxt.cmp_buf[idx][11:8] = wdata[3:0];
                        end else begin
                            s_nxt.cmp_buf[idx][7:0] = wdata;
                        end
                        // Mirror second-waveform writes onto the first one.
                        if (s_r.fifty && idx[1]) begin
                            if (addr[0]) begin
                                s_nxt.cmp_buf[{1'b0, idx[0]}][11:8] = wdata[3:0];
                            end else begin
                                s_nxt.cmp_buf[{1'b0, idx[0]}][7:0] = wdata;
                            end
                        end
                        cmd_req_ok = s_r.auto_load && !s_r.cmd_busy;
                        if (cmd_req_ok && (addr == OFS_SECOND_CLEAR_HIGH ||
                            (s_r.fifty && addr == OFS_FIRST_CLEAR_HIGH))) begin
                            s_nxt.cmd_code = 5'h01;
                            s_nxt.cmd_busy = 1'b1;
                            s_nxt.cmd_cnt  = 2'h0;
                        end
                    end
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Register reads; unmapped offsets read as zero.
        if (rd_en) begin
            unique case (addr)
                OFS_CLOCK_PRESCALE_ENABLE_CTRL:
                    s_nxt.rdata = {1'b0, s_r.clk_src, s_r.cdiv, s_r.xdiv, s_r.enable};
                OFS_RAMP_AND_OVERRIDE_CTRL:   s_nxt.rdata = {6'h00, s_r.ramp};
                OFS_OUTPUT_ROUTE_UPDATE_CTRL:
                    s_nxt.rdata = {s_r.d_route, s_r.c_route, 2'h0, s_r.fifty, 1'b0, s_r.auto_load, s_r.ovr};
                OFS_OVERRIDE_LEVEL_CTRL:      s_nxt.rdata = s_r.levels;
                OFS_COMMAND_STROBE_CTRL:      s_nxt.rdata = RESET_BYTE;
                OFS_STATUS:                   s_nxt.rdata = {6'h00, s_r.cmd_rdy, s_r.en_rdy};
                OFS_CAPTURE_FIRST_LOW:        s_nxt.rdata = s_r.cap_a[7:0];
                OFS_CAPTURE_FIRST_HIGH:       s_nxt.rdata = {4'h0, s_r.cap_a[11:8]};
                OFS_CAPTURE_SECOND_LOW:       s_nxt.rdata = s_r.cap_b[7:0];
                OFS_CAPTURE_SECOND_HIGH:      s_nxt.rdata = {4'h0, s_r.cap_b[11:8]};
                default: begin
                    if (addr[5:3] == OFS_COMPARE_BLOCK) begin
                        nib = s_r.cmp_buf[addr[2:1]][11:8];
                        s_nxt.rdata = addr[0] ? {4'h0, nib} : s_r.cmp_buf[addr[2:1]][7:0];
                    end
                end
            endcase
        end

        // Status flags follow the crossings, so they drop right after a write.
        s_nxt.en_rdy  = !s_nxt.en_busy && !s_nxt.dis_arm;
        s_nxt.cmd_rdy = !s_nxt.cmd_busy;

        ////////////////////////////////////////////////////////////////////////
        // Waveform override; single ramp picks only each waveform's own phases
        // because the two compare windows may overlap there.
        if (!s_r.ovr) begin
            s_nxt.wave_a = wave_a_raw;
            s_nxt.wave_b = wave_b_raw;
        end else if (s_r.ramp == SINGLE_RAMP) begin
            s_nxt.wave_a = s_r.levels[{2'h0, phase_a_on}];
            s_nxt.wave_b = s_r.levels[{2'h3, phase_b_on}];
        end else begin
            s_nxt.wave_a = s_r.levels[{1'b0, ramp_phase}];
            s_nxt.wave_b = s_r.levels[{1'b1, ramp_phase}];
        end
        s_nxt.out_c = s_r.c_route ? s_nxt.wave_b : s_nxt.wave_a;
        s_nxt.out_d = s_r.d_route ? s_nxt.wave_b : s_nxt.wave_a;
    end

    // One register holds the whole state.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign rdata              = s_r.rdata;
    assign core_enable        = s_r.core_en;
    assign count_tick         = s_r.count_tick;
    assign sync_tick          = s_r.sync_tick;
    assign core_clock_source  = s_r.clk_src;
    assign ramp_mode_field    = s_r.ramp;
    assign enable_ready_flag  = s_r.en_rdy;
    assign command_ready_flag = s_r.cmd_rdy;
    assign capture_a_pulse    = s_r.cap_a_p;
    assign capture_b_pulse    = s_r.cap_b_p;
    assign restart_pulse      = s_r.restart_p;
    assign load_pulse         = s_r.load_p;
    assign cmp_a_set          = s_r.cmp_act[CMP_A_SET];
    assign cmp_a_clr          = s_r.cmp_act[CMP_A_CLR];
    assign cmp_b_set          = s_r.cmp_act[CMP_B_SET];
    assign cmp_b_clr          = s_r.cmp_act[CMP_B_CLR];
    assign waveform_a         = s_r.wave_a;
    assign waveform_b         = s_r.wave_b;
    assign out_c_wave         = s_r.out_c;
    assign out_d_wave         = s_r.out_d;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the control behaviour.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_enable_write_drops_ready;
        wr_en && addr == OFS_CLOCK_PRESCALE_ENABLE_CTRL && s_r.en_rdy |=> !enable_ready_flag ##1 !enable_ready_flag;
    endproperty
    a_enable_write_drops_ready: assert property (p_enable_write_drops_ready) else $error("enable ready stayed high");

    property p_enable_crosses;
        $rose(s_r.en_busy) && !s_r.dis_arm |-> ##[1:20] (!s_r.en_busy && core_enable == s_r.enable);
    endproperty
    a_enable_crosses: assert property (p_enable_crosses) else $error("enable did not reach core side");

    property p_fields_locked;
        wr_en && addr == OFS_CLOCK_PRESCALE_ENABLE_CTRL && (s_r.core_en || s_r.enable) |=> $stable(s_r.cdiv);
    endproperty
    a_fields_locked: assert property (p_fields_locked) else $error("locked field changed");

    property p_disable_ignored;
        wr_en && addr == OFS_COMMAND_STROBE_CTRL && s_r.en_busy && !s_r.dis_arm |=> !s_r.dis_arm;
    endproperty
    a_disable_ignored: assert property (p_disable_ignored) else $error("disable accepted while crossing");

    property p_command_ignored;
        wr_en && addr == OFS_COMMAND_STROBE_CTRL && s_r.cmd_busy |=> $stable(s_r.cmd_code);
    endproperty
    a_command_ignored: assert property (p_command_ignored) else $error("command accepted while busy");

    property p_command_ready_drops;
        wr_en && addr == OFS_COMMAND_STROBE_CTRL && |wdata[4:0] && command_ready_flag
            |=> !command_ready_flag ##[1:20] command_ready_flag;
    endproperty
    a_command_ready_drops: assert property (p_command_ready_drops) else $error("command ready misbehaved");

    property p_no_override_passthrough;
        !s_r.ovr |=> waveform_a == $past(wave_a_raw) && waveform_b == $past(wave_b_raw);
    endproperty
    a_no_override_passthrough: assert property (p_no_override_passthrough) else $error("levels leaked");

    property p_route_c;
        out_c_wave == ($past(s_r.c_route) ? waveform_b : waveform_a);
    endproperty
    a_route_c: assert property (p_route_c) else $error("output C routed wrongly");

    property p_strobe_reads_zero;
        rd_en && addr == OFS_COMMAND_STROBE_CTRL |=> rdata == 8'h00;
    endproperty
    a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("strobe register read nonzero");

    property p_mirror_low;
        wr_en && addr == 6'h2C && s_r.fifty |=> s_r.cmp_buf[CMP_A_SET][7:0] == $past(wdata);
    endproperty
    a_mirror_low: assert property (p_mirror_low) else $error("mirror write missing");
endmodule

// >>> verification/pwm_timer_control_regs_tb_top.sv
`timescale 1ns/1ns
module pwm_timer_control_regs_tb_top;
    import pwm_ctrl_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, cycle_end = 1'b0;
    logic phase_a_on = 1'b0, phase_b_on = 1'b0, wave_a_raw = 1'b0, wave_b_raw = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00, rdata, rv;
    logic [11:0] counter_value = 12'h000, cmp_a_clr, cmp_b_clr;
    logic [1:0] ramp_phase = 2'h0;
    logic core_enable, en_rdy, cmd_rdy, waveform_a, waveform_b, out_c_wave, out_d_wave;
    logic cnt_tick, rst_p;
    logic [1:0] clk_src, ramp_mode;
    int err_count = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period of 20 ns.
    always #20 ref_clk = ~ref_clk;
    pwm_timer_control_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cycle_end(cycle_end), .counter_value(counter_value),
        .ramp_phase(ramp_phase), .phase_a_on(phase_a_on), .phase_b_on(phase_b_on), .wave_a_raw(wave_a_raw),
        .wave_b_raw(wave_b_raw), .core_enable(core_enable), .count_tick(cnt_tick), .sync_tick(),
        .core_clock_source(clk_src), .ramp_mode_field(ramp_mode), .enable_ready_flag(en_rdy),
        .command_ready_flag(cmd_rdy), .capture_a_pulse(), .capture_b_pulse(), .restart_pulse(rst_p),
        .load_pulse(), .cmp_a_set(), .cmp_a_clr(cmp_a_clr), .cmp_b_set(), .cmp_b_clr(cmp_b_clr),
        .waveform_a(waveform_a), .waveform_b(waveform_b), .out_c_wave(out_c_wave), .out_d_wave(out_d_wave));
    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks keep every strobe one cycle long, as the port expects.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk); addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge ref_clk); wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [5:0] a);
        @(posedge ref_clk); addr <= a; rd_en <= 1'b1;
        @(posedge ref_clk); rd_en <= 1'b0;
        #1 rv = rdata;
    endtask
    // A bounded wait, so a flag that never returns shows up as a mismatch later.
    // Flags are read 1 ns after an edge, once a write that just landed has dropped them.
    task automatic wait_flag(input bit cmd);
        #1;
        for (int i = 0; i < 200 && (cmd ? cmd_rdy : en_rdy) !== 1'b1; i++) begin
            @(posedge ref_clk); #1;
        end
    endtask
    task automatic pulse_end();
        @(posedge ref_clk); cycle_end <= 1'b1;
        @(posedge ref_clk); cycle_end <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios: reset values, enable crossing, commands, mirror and loads, routing, override, disable.
    task automatic t_reset();
        for (int a = 1; a < 5; a++) begin
            rd(6'(a)); chk(rv, 16'h0000);
        end
        rd(6'h3f); chk(rv, 16'h0000);
        rd(OFS_STATUS); chk(rv, 16'h0003);
        $display("reset test done");
    endtask
    task automatic t_enable();
        wr(6'h00, 8'h06); rd(6'h00); chk(rv, 16'h0006);
        wait_flag(0);
        wr(6'h00, 8'h07); #1 chk(en_rdy, 1'b0);
        wait_flag(0); chk(core_enable, 1'b1);
        wr(6'h00, 8'h1f); wait_flag(0); rd(6'h00); chk(rv, 16'h0007);
        $display("enable test done");
    endtask
    task automatic t_command();
        @(posedge ref_clk); counter_value <= 12'habc;
        wr(6'h04, 8'h08); wr(6'h04, 8'h10); rd(6'h04); chk(rv, 16'h0000);
        wait_flag(1);
        rd(6'h22); chk(rv, 16'h00bc);
        rd(6'h23); chk(rv, 16'h000a);
        rd(6'h24); chk(rv, 16'h0000);
        wr(6'h04, 8'h04); wait_flag(1); chk(rst_p, 1'b1);
        $display("command test done");
    endtask
    task automatic t_mirror();
        wr(6'h02, 8'h08); wr(6'h2e, 8'h34); wr(6'h2c, 8'h5a); rd(6'h28); chk(rv, 16'h005a);
        wr(6'h2f, 8'h02); wr(6'h04, 8'h02); wait_flag(1);
        @(posedge ref_clk); #1 chk(cmp_a_clr, 12'h234);
        chk(cmp_b_clr, 12'h234);
        wr(6'h02, 8'h0a); wr(6'h2b, 8'h05); #1 chk(cmd_rdy, 1'b0);
        wait_flag(1); chk(cmp_a_clr, 12'h234);
        pulse_end(); chk(cmp_a_clr, 12'h534);
        wr(6'h2f, 8'h06); wait_flag(1); pulse_end(); chk(cmp_b_clr, 12'h634);
        $display("mirror test done");
    endtask
    task automatic t_route();
        @(posedge ref_clk); wave_a_raw <= 1'b1; wave_b_raw <= 1'b0;
        wr(6'h02, 8'h40); repeat (2) @(posedge ref_clk);
        #1 chk({out_d_wave, out_c_wave}, 2'h2);
        wr(6'h02, 8'h80); repeat (2) @(posedge ref_clk);
        #1 chk({out_d_wave, out_c_wave}, 2'h1);
        $display("route test done");
    endtask
    task automatic t_override();
        @(posedge ref_clk); wave_a_raw <= 1'b0; phase_a_on <= 1'b1; ramp_phase <= 2'h2;
        wr(6'h01, 8'h00); wr(6'h03, 8'h42); wr(6'h02, 8'h00); repeat (2) @(posedge ref_clk);
        #1 chk({waveform_a, waveform_b}, 2'h0);
        wr(6'h02, 8'h01); repeat (2) @(posedge ref_clk);
        #1 chk({waveform_a, waveform_b}, 2'h3);
        wr(6'h01, 8'h01); repeat (2) @(posedge ref_clk);
        #1 chk({waveform_a, waveform_b}, 2'h1);
        chk(ramp_mode, 2'h1);
        $display("override test done");
    endtask
    task automatic t_disable();
        wr(6'h04, 8'h80); repeat (3) @(posedge ref_clk);
        #1 chk({en_rdy, core_enable}, 2'h1);
        pulse_end(); wait_flag(0); chk(core_enable, 1'b0);
        rd(6'h00); chk(rv, 16'h0006);
        $display("disable test done");
    endtask
    // Divide by four: any 32 running cycles hold exactly eight counter ticks.
    task automatic t_divider();
        int n = 0;
        wr(6'h00, 8'h48); wait_flag(0); chk(clk_src, 2'h2);
        wr(6'h00, 8'h49); wait_flag(0);
        repeat (32) begin
            @(posedge ref_clk); #1 n += cnt_tick;
        end
        chk(16'(n), 16'h0008);
        $display("divider test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // The one place where the run ends.
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_reset(); t_enable(); t_command(); t_mirror(); t_route(); t_override(); t_disable(); t_divider();
        end_of_test();
    end
endmodule
